// [verif/tape_unit_model.sv]
module tape_unit_model (
	input  wire logic sys_clk,    // system clock
	output logic      readStrobe, // one pulse per character
	output logic [8:0] trk        // parity track on bit 8
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] lrc = 9'h000;
	initial readStrobe = 1'h0;
	initial trk = 9'h000;
	// lines scramble once the strobe drops, so stale data never passes
	task automatic put(input logic [8:0] c);
		@(posedge sys_clk);
		readStrobe <= 1'h1;
		trk <= c;
		lrc = lrc ^ c;
		@(posedge sys_clk);
		readStrobe <= 1'h0;
		trk <= ~c;
	endtask
	// check character makes every track count even
	task automatic endBlock();
		put(lrc);
		lrc = 9'h000;
	endtask
	// a new block builds its check character from nothing
	task automatic newBlock();
		lrc = 9'h000;
	endtask
endmodule // tape_unit_model

// [verif/tb_tape_read_parity_checker.sv]
module tb_tape_read_parity_checker;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'h0, srst = 1'h1, sense = 1'h0, seven = 1'h0, blkRst = 1'h0, disp = 1'h0;
	logic       readStrobe, vertErr, longErr;
	logic [8:0] trk, errN;
	int         fails = 0, compares = 0, cycles = 0;
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cycles <= cycles + 1;
	always @(posedge sys_clk) if (cycles == 400) close_out();
	tape_unit_model tu (.sys_clk(sys_clk), .readStrobe(readStrobe), .trk(trk));
	tape_read_parity_checker dut (.sys_clk(sys_clk), .srst(srst), .readStrobe(readStrobe),
		.read_parity_track(trk[8]), .readData(trk[7:0]), .parity_sense_select(sense),
		.sevenTrackMode(seven), .blockReset(blkRst), .displayPeriod(disp),
		.vertParityErr(vertErr), .trackErr_n(errN), .longParityErr(longErr));
	task automatic check(input string n, input logic [8:0] e, input logic [8:0] s);
		compares++;
		if (s !== e) fails++;
		if (s !== e) $display("BAD %s expected %h seen %h", n, e, s);
	endtask
	// both senses in both formats; seven-bit pins the two low tracks high
	task automatic vertical();
		logic [8:0] c;
		for (int i = 0; i < 8; i++)
		begin
			c = 9'h0a5 ^ 9'(i * 73);
			@(posedge sys_clk);
			sense <= i[0];
			seven <= i[1];
			tu.put(c);
			#1 check("vertErr", 9'(^(i[1] ? {c[8:2], 2'h3} : c) ^ i[0]), 9'(vertErr));
		end
	endtask
	// the previous test's toggles cancel, so the block reset meets stages that are already clear
	task automatic longitudinal();
		@(posedge sys_clk);
		seven <= 1'h0;
		blkRst <= 1'h1;
		tu.newBlock();
		@(posedge sys_clk);
		blkRst <= 1'h0;
		tu.put(9'h181);
		tu.put(9'h103);
		#1 check("trackErr_n", 9'h1ff, errN);
		check("longErr", 9'h001, 9'(longErr));
		@(posedge sys_clk);
		disp <= 1'h1;
		#1 check("trackErr_n", 9'h17d, errN);
		tu.endBlock();
		#1 check("trackErr_n", 9'h1ff, errN);
		check("longErr", 9'h000, 9'(longErr));
	endtask
	task automatic close_out();
		if (cycles >= 400) fails++;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk);
		srst <= 1'h0;
		vertical();
		longitudinal();
		close_out();
	end
endmodule // tb_tape_read_parity_checker

// [verilog/parity_check_pkg.sv]
package parity_check_pkg;
	localparam int TRACKS     = 9;   // parity track plus eight data tracks
	localparam int DATA_BITS  = 8;
	localparam int PAR_POS    = 8;   // parity track sits above the data tracks
	localparam int LOW_TRACKS = 2;   // tracks forced to one in seven-bit format
	localparam logic [1:0] LOW_ONES = 2'h3;
	localparam logic [8:0] TRACKS_CLEAR = 9'h000;
	localparam logic       BIT_CLEAR = 1'h0;
endpackage

// [verilog/tape_read_parity_checker.sv]
module tape_read_parity_checker (
	input  wire logic       sys_clk,              // 10 MHz system clock
	input  wire logic       srst,                 // synchronous reset, active high
	input  wire logic       readStrobe,           // one pulse per read character
	input  wire logic       read_parity_track,    // parity track bit
	input  wire logic [7:0] readData,             // data tracks, bit 0 is read_track_zero
	input  wire logic       parity_sense_select,  // 1 = odd sense, 0 = even sense
	input  wire logic       sevenTrackMode,       // 1 = seven-bit character format
	input  wire logic       blockReset,           // clears track stages at block start
	input  wire logic       displayPeriod,        // enables the track indicators
	output logic            vertParityErr,        // high while last character failed
	output logic [8:0]      trackErr_n,           // per-track indicators, low = error
	output logic            longParityErr         // any track stage set
);
	logic [8:0] rawCharacter;  // tracks as read, parity track on top
	logic [8:0] character;     // tracks after seven-bit pinning
	logic [8:0] liveMask;      // stages that count in the current format
	logic [8:0] toggleReq;     // per-track toggle request for this cycle
	logic [8:0] trackStage_q;  // longitudinal toggle stages
	logic [8:0] trackStage_d;  // next value of the stages
	logic       vertErr_q;     // vertical error level
	logic       vertErr_d;     // next value of the vertical level

	// seven-bit format: the two low data tracks carry no data and read as ones
	function automatic logic [8:0] pinLowTracks(input logic [8:0] raw, input logic seven);
		logic [8:0] pinned;
		pinned = raw;
		if (seven)
			pinned[parity_check_pkg::LOW_TRACKS-1:0] = parity_check_pkg::LOW_ONES;
		return pinned;
	endfunction

	// stages that may toggle; a pinned track would flip on every character and lie
	function automatic logic [8:0] countedTracks(input logic seven);
		logic [8:0] mask;
		mask = ~parity_check_pkg::TRACKS_CLEAR;
		if (seven)
			mask[parity_check_pkg::LOW_TRACKS-1:0] = ~parity_check_pkg::LOW_ONES;
		return mask;
	endfunction

	// one flag for both senses: even sense fails an odd count, odd sense an even one
	function automatic logic vertFault(input logic [8:0] ch, input logic oddSense);
		return (^ch) ^ oddSense;
	endfunction

	// pin once, so the vertical and longitudinal checks see the same bits
	always_comb
	begin
		rawCharacter = {read_parity_track, readData};
		character    = pinLowTracks(rawCharacter, sevenTrackMode);
		liveMask     = countedTracks(sevenTrackMode);
	end

	// vertical check; the level holds between strobes so a slow reader still sees it
	always_comb
	begin
		vertErr_d = vertErr_q;
		if (readStrobe)
			vertErr_d = vertFault(character, parity_sense_select);
	end

	// vertical level register
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			vertErr_q <= parity_check_pkg::BIT_CLEAR;
		else
			vertErr_q <= vertErr_d;
	end

	// a registered level, not a pulse, so it never glitches between strobes
	assign vertParityErr = vertErr_q;

	// nine identical stages, each asking to toggle on a one read under the strobe in a track that liveMask counts
	genvar t;
	generate
		for (t = 0; t < parity_check_pkg::TRACKS; t = t + 1)
		begin : g_stage
			// the strobe qualifies the toggle, so each character counts exactly once
			assign toggleReq[t] = readStrobe & character[t] & liveMask[t];
			// lamp lit only in the display period; a clear stage keeps it dark
			assign trackErr_n[t] = ~(trackStage_q[t] & displayPeriod);
		end
	endgenerate

	// block reset wins over a strobe in the same cycle, so every block starts clean
	always_comb
	begin
		trackStage_d = trackStage_q ^ toggleReq;
		if (blockReset)
			trackStage_d = parity_check_pkg::TRACKS_CLEAR;
	end

	// stage register
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			trackStage_q <= parity_check_pkg::TRACKS_CLEAR;
		else
			trackStage_q <= trackStage_d;
	end

	// combined error does not wait for the display period
	assign longParityErr = |trackStage_q;

	// the checks below work from the pins, not from the pinned character,
	// so a fault in the pinning logic cannot hide behind its own copy

	// strobed characters, split by format because pinned tracks change the count
	sequence s_char_nine;
		readStrobe && !sevenTrackMode;
	endsequence

	sequence s_char_seven;
		readStrobe && sevenTrackMode;
	endsequence

	// counted characters: a block reset in the same cycle takes precedence
	sequence s_count_nine;
		readStrobe && !sevenTrackMode && !blockReset;
	endsequence

	sequence s_count_seven;
		readStrobe && sevenTrackMode && !blockReset;
	endsequence

	// block reset, one idle cycle, then the first nine-track character of the block
	sequence s_clear_then_char;
		blockReset ##1 (!blockReset && !readStrobe) ##1 s_count_nine;
	endsequence

	// nine-track character: the flag follows the count and the sense
	a_vert_level: assert property (@(posedge sys_clk) disable iff (srst)
		s_char_nine |=> vertParityErr ==
		($past(^{read_parity_track, readData}) ^ $past(parity_sense_select)))
		else $error("vertical parity level wrong");

	// seven-bit character: the two pinned ones leave the parity of the count alone
	a_vert_seven: assert property (@(posedge sys_clk) disable iff (srst)
		s_char_seven |=> vertParityErr ==
		($past(^{read_parity_track,
		readData[parity_check_pkg::DATA_BITS-1:parity_check_pkg::LOW_TRACKS]})
		^ $past(parity_sense_select)))
		else $error("seven-bit vertical level wrong");

	// the level stands until the next strobe
	a_vert_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!readStrobe |=> $stable(vertParityErr))
		else $error("vertical flag moved without strobe");

	// block reset empties every stage, even beside a strobe
	a_block_clear: assert property (@(posedge sys_clk) disable iff (srst)
		blockReset |=> trackStage_q == parity_check_pkg::TRACKS_CLEAR)
		else $error("block reset left a stage set");

	// a nine-track character toggles exactly the tracks that read one
	a_track_toggle: assert property (@(posedge sys_clk) disable iff (srst)
		s_count_nine |=>
		trackStage_q == ($past(trackStage_q) ^ $past({read_parity_track, readData})))
		else $error("track stage did not toggle");

	// no strobe, no count
	a_no_strobe: assert property (@(posedge sys_clk) disable iff (srst)
		!readStrobe && !blockReset |=> $stable(trackStage_q))
		else $error("stage changed without strobe");

	// lamps stay dark outside the display period
	a_display_gate: assert property (@(posedge sys_clk) disable iff (srst)
		!displayPeriod |-> trackErr_n == ~parity_check_pkg::TRACKS_CLEAR)
		else $error("indicator lit outside display");

	// during the display period each lamp shows its own stage
	a_display_on: assert property (@(posedge sys_clk) disable iff (srst)
		displayPeriod |-> trackErr_n == ~trackStage_q)
		else $error("indicator mismatch in display");

	// the combined error is set whenever any stage is set
	a_long_any: assert property (@(posedge sys_clk) disable iff (srst)
		longParityErr == (trackStage_q != parity_check_pkg::TRACKS_CLEAR))
		else $error("combined error wrong");

	// seven-bit format freezes the pinned stages
	a_seven_low: assert property (@(posedge sys_clk) disable iff (srst)
		s_count_seven |=> trackStage_q[parity_check_pkg::LOW_TRACKS-1:0] ==
		$past(trackStage_q[parity_check_pkg::LOW_TRACKS-1:0]))
		else $error("pinned tracks toggled");

	// and still counts every other track
	a_seven_upper: assert property (@(posedge sys_clk) disable iff (srst)
		s_count_seven |=>
		trackStage_q[parity_check_pkg::TRACKS-1:parity_check_pkg::LOW_TRACKS] ==
		$past(trackStage_q[parity_check_pkg::TRACKS-1:parity_check_pkg::LOW_TRACKS]
		^ {read_parity_track,
		readData[parity_check_pkg::DATA_BITS-1:parity_check_pkg::LOW_TRACKS]}))
		else $error("upper stage missed a toggle in seven-bit format");

	// the first character of a fresh block lands on empty stages
	a_block_fresh: assert property (@(posedge sys_clk) disable iff (srst)
		s_clear_then_char |=> trackStage_q == $past({read_parity_track, readData}))
		else $error("fresh block did not start from clear stages");

	// a block reset also drops the combined error
	a_clear_quiet: assert property (@(posedge sys_clk) disable iff (srst)
		blockReset |=> !longParityErr)
		else $error("combined error survived block reset");

	// in the display period the combined error agrees with the lamps
	a_display_long: assert property (@(posedge sys_clk) disable iff (srst)
		displayPeriod |-> longParityErr == (trackErr_n != ~parity_check_pkg::TRACKS_CLEAR))
		else $error("combined error disagrees with lamps");

endmodule // tape_read_parity_checker
